// ---- src/dmx_pkg.sv ----
// Constants for the data-move instruction execution block
package dmx_pkg;
    // Register byte offsets on the APB slave
    localparam logic [7:0] OFS_INSTR = 8'h00;
    localparam logic [7:0] OFS_ACC = 8'h04;
    localparam logic [7:0] OFS_STATUS = 8'h08;
    localparam logic [7:0] OFS_FADDR = 8'h0C;
    localparam logic [7:0] OFS_FDATA = 8'h10;
    localparam logic [7:0] OFS_COUNT = 8'h14;
    // Status field positions
    localparam int ZERO_BIT = 0;
    localparam int UNSUP_BIT = 1;
    // Reset values
    localparam logic [7:0] ACC_RST = 8'h00;
    localparam logic [7:0] FILE_RST = 8'h00;
    localparam logic [15:0] COUNT_RST = 16'h0000;
    // Instruction word layout, 14 bits
    localparam int INSTR_W = 14;
    localparam int DEST_BIT = 7;
    // Opcode patterns after masking out operand and don't-care bits
    localparam logic [13:0] COPY_MASK = 14'h3F00;
    localparam logic [13:0] COPY_CODE = 14'h0800;
    localparam logic [13:0] STORE_MASK = 14'h3F80;
    localparam logic [13:0] STORE_CODE = 14'h0080;
    localparam logic [13:0] LOAD_MASK = 14'h3C00;
    localparam logic [13:0] LOAD_CODE = 14'h3000;
    localparam logic [13:0] IDLE_MASK = 14'h3F9F;
    localparam logic [13:0] IDLE_CODE = 14'h0000;
    // Number of file registers
    localparam int FILE_DEPTH = 128;
endpackage

// ---- src/dmx_exec.sv ----
// Data-move instruction executor with APB register access
// Summary of operation
// - copy_register with d=0 loads file into accumulator
// - copy_register with d=1 writes file back unchanged
// - copy_register always updates the zero flag
// - copy_register d=1 acts as register zero test
// - store_accumulator writes accumulator into file, flags untouched
// - load_immediate loads literal, flags untouched
// - load_immediate don't-care bits ignored in decode
//
// The APB slave port and the register addresses were decided locally.
`timescale 1ns/1ps
module dmx_exec (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr
);
    // ****************************************
    // APB slave
    // ****************************************
    logic pready_reg;
    logic [31:0] prdata_reg;
    logic pslverr_reg;
    logic acc_done;
    logic apb_wr;
    logic addr_ok;
    logic [7:0] acc_reg;
    logic zero_reg;
    logic unsup_reg;
    logic [6:0] faddr_reg;
    logic [15:0] count_reg;
    logic [7:0] file_mem [dmx_pkg::FILE_DEPTH];

    assign acc_done = psel & penable & pready_reg;
    assign apb_wr = acc_done & pwrite;

    // Address decode for the error answer; read data decodes paddr in its own case
    always_comb
    begin
        unique case (paddr)
            dmx_pkg::OFS_INSTR, dmx_pkg::OFS_ACC, dmx_pkg::OFS_STATUS,
            dmx_pkg::OFS_FADDR, dmx_pkg::OFS_FDATA, dmx_pkg::OFS_COUNT:
                addr_ok = 1'b1;
            default:
                addr_ok = 1'b0;
        endcase
    end

    // One wait state: pready rises the cycle after the access starts
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pready_reg <= 1'b0;
            pslverr_reg <= 1'b0;
            prdata_reg <= 32'h0000_0000;
        end
        else
        begin
            pready_reg <= psel & penable & ~pready_reg;
            pslverr_reg <= psel & penable & ~pready_reg & ~addr_ok;
            prdata_reg <= 32'h0000_0000;
            if (psel & penable & ~pready_reg & ~pwrite)
            begin
                unique case (paddr)
                    dmx_pkg::OFS_ACC: prdata_reg <= {24'h000000, acc_reg};
                    dmx_pkg::OFS_STATUS:
                        prdata_reg <= {30'h0000_0000, unsup_reg, zero_reg};
                    dmx_pkg::OFS_FADDR:
                        prdata_reg <= {25'h0000000, faddr_reg};
                    dmx_pkg::OFS_FDATA:
                        prdata_reg <= {24'h000000, file_mem[faddr_reg]};
                    dmx_pkg::OFS_COUNT:
                        prdata_reg <= {16'h0000, count_reg};
                    default: prdata_reg <= 32'h0000_0000;
                endcase
            end
        end
    end

    assign pready = pready_reg;
    assign prdata = prdata_reg;
    assign pslverr = pslverr_reg;

    // ****************************************
    // Instruction decode
    // ****************************************
    logic [13:0] iw;
    logic exec;
    logic is_copy;
    logic is_store;
    logic is_load;
    logic is_idle;
    logic dest_file;
    logic [6:0] f_idx;
    logic [7:0] src_val;

    assign iw = pwdata[dmx_pkg::INSTR_W-1:0];
    assign exec = apb_wr & (paddr == dmx_pkg::OFS_INSTR);
    assign is_copy = (iw & dmx_pkg::COPY_MASK) == dmx_pkg::COPY_CODE;
    assign is_store = (iw & dmx_pkg::STORE_MASK) == dmx_pkg::STORE_CODE;
    // Bits 9:8 are masked off, so stray don't-cares still decode
    assign is_load = (iw & dmx_pkg::LOAD_MASK) == dmx_pkg::LOAD_CODE;
    assign is_idle = (iw & dmx_pkg::IDLE_MASK) == dmx_pkg::IDLE_CODE;
    assign dest_file = iw[dmx_pkg::DEST_BIT];
    assign f_idx = iw[6:0];
    assign src_val = file_mem[f_idx];

    // ****************************************
    // Execution state
    // ****************************************
    // Accumulator: copy with d=0, load and APB writes to OFS_ACC write it, nothing else does
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            acc_reg <= dmx_pkg::ACC_RST;
        else if (exec & is_copy & ~dest_file)
            acc_reg <= src_val;
        else if (exec & is_load)
            acc_reg <= iw[7:0];
        else if (apb_wr & (paddr == dmx_pkg::OFS_ACC))
            acc_reg <= pwdata[7:0];
    end

    // Zero flag moves only on copy and on writes to OFS_STATUS; store and load leave it alone
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            zero_reg <= 1'b0;
        else if (exec & is_copy)
            zero_reg <= (src_val == 8'h00);
        else if (apb_wr & (paddr == dmx_pkg::OFS_STATUS))
            zero_reg <= pwdata[dmx_pkg::ZERO_BIT];
    end

    // Sticky flag for words outside the four handled opcodes
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            unsup_reg <= 1'b0;
        else if (exec & ~(is_copy | is_store | is_load | is_idle))
            unsup_reg <= 1'b1;
        else if (apb_wr & (paddr == dmx_pkg::OFS_STATUS)
                 & pwdata[dmx_pkg::UNSUP_BIT])
            unsup_reg <= 1'b0;
    end

    // Pointer for software access to the file
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            faddr_reg <= 7'h00;
        else if (apb_wr & (paddr == dmx_pkg::OFS_FADDR))
            faddr_reg <= pwdata[6:0];
    end

    // File registers; copy d=1 rewrites the same value, a pure test
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            for (int i = 0; i < dmx_pkg::FILE_DEPTH; i++)
                file_mem[i] <= dmx_pkg::FILE_RST;
        end
        else if (exec & is_copy & dest_file)
            file_mem[f_idx] <= src_val;
        else if (exec & is_store)
            file_mem[f_idx] <= acc_reg;
        else if (apb_wr & (paddr == dmx_pkg::OFS_FDATA))
            file_mem[faddr_reg] <= pwdata[7:0];
    end

    // Every accepted word completes in the cycle it is written
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            count_reg <= dmx_pkg::COUNT_RST;
        else if (exec)
            count_reg <= count_reg + 16'h0001;
    end

    // ****************************************
    // Assertions
    // ****************************************
    sequence s_exec_copy_w;
        exec && is_copy && !dest_file;
    endsequence

    sequence s_exec_copy_f;
        exec && is_copy && dest_file;
    endsequence

    sequence s_access_wait;
        psel && penable && !pready_reg;
    endsequence

    property p_copy_w;
        @(posedge pclk) disable iff (!presetn)
        s_exec_copy_w |=> acc_reg == $past(src_val);
    endproperty
    a_copy_w: assert property (p_copy_w)
        else $error("copy to accumulator lost value");

    property p_copy_f;
        @(posedge pclk) disable iff (!presetn)
        s_exec_copy_f |=> $stable(acc_reg)
            && file_mem[$past(f_idx)] == $past(src_val);
    endproperty
    a_copy_f: assert property (p_copy_f)
        else $error("copy to file changed data or accumulator");

    property p_zero;
        @(posedge pclk) disable iff (!presetn)
        exec && is_copy |=> zero_reg == ($past(src_val) == 8'h00);
    endproperty
    a_zero: assert property (p_zero)
        else $error("zero flag wrong after copy");

    property p_test;
        @(posedge pclk) disable iff (!presetn)
        s_exec_copy_f ##1 (pready_reg == 1'b0) |-> $stable(acc_reg);
    endproperty
    a_test: assert property (p_test)
        else $error("register test disturbed accumulator");

    property p_store;
        @(posedge pclk) disable iff (!presetn)
        exec && is_store |=> file_mem[$past(f_idx)] == $past(acc_reg)
            && $stable(zero_reg);
    endproperty
    a_store: assert property (p_store)
        else $error("store wrong or flag changed");

    property p_load;
        @(posedge pclk) disable iff (!presetn)
        exec && is_load |=> acc_reg == $past(pwdata[7:0])
            && $stable(zero_reg);
    endproperty
    a_load: assert property (p_load)
        else $error("literal load wrong or flag changed");

    property p_ignore;
        @(posedge pclk) disable iff (!presetn)
        exec && iw[13:10] == 4'hC |-> is_load;
    endproperty
    a_ignore: assert property (p_ignore)
        else $error("don't-care bits affected literal decode");

    property p_idle;
        @(posedge pclk) disable iff (!presetn)
        exec && is_idle |=> $stable(acc_reg) && $stable(zero_reg)
            && count_reg == $past(count_reg) + 16'h0001;
    endproperty
    a_idle: assert property (p_idle)
        else $error("idle changed state or took extra cycles");

    property p_wait;
        @(posedge pclk) disable iff (!presetn)
        s_access_wait |=> pready_reg ##1 !pready_reg;
    endproperty
    a_wait: assert property (p_wait)
        else $error("bus answer not one cycle wide");
endmodule

// ---- bench/tb_top.sv ----
// Self-checking testbench for the data-move instruction executor
`timescale 1ns/1ps
module tb_top;
    typedef struct packed {
        logic [6:0] fa;
        logic [7:0] fv;
        logic [7:0] acc;
        logic z;
        logic [13:0] ins;
        logic [7:0] eacc;
        logic ez;
        logic [7:0] ef;
    } dmx_row_type;
    logic pclk;
    logic presetn;
    logic psel;
    logic penable;
    logic pwrite;
    logic [7:0] paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic [31:0] rd;
    logic er;
    int err_total;
    int samples_checked;
    // Inputs beside expected accumulator, zero flag and file value
    dmx_row_type rows [10] = '{
        '{7'h05, 8'h3C, 8'h11, 1'h1, 14'h0805, 8'h3C, 1'h0, 8'h3C},
        '{7'h7F, 8'h00, 8'hFF, 1'h0, 14'h087F, 8'h00, 1'h1, 8'h00},
        '{7'h40, 8'h00, 8'h22, 1'h0, 14'h08C0, 8'h22, 1'h1, 8'h00},
        '{7'h01, 8'h81, 8'h33, 1'h1, 14'h0881, 8'h33, 1'h0, 8'h81},
        '{7'h00, 8'h55, 8'h4F, 1'h1, 14'h0080, 8'h4F, 1'h1, 8'h4F},
        '{7'h7F, 8'hFF, 8'h00, 1'h0, 14'h00FF, 8'h00, 1'h0, 8'h00},
        '{7'h10, 8'h77, 8'h00, 1'h1, 14'h335A, 8'h5A, 1'h1, 8'h77},
        '{7'h10, 8'h77, 8'hC3, 1'h0, 14'h3000, 8'h00, 1'h0, 8'h77},
        '{7'h03, 8'h99, 8'h12, 1'h1, 14'h0000, 8'h12, 1'h1, 8'h99},
        '{7'h03, 8'h99, 8'h12, 1'h0, 14'h0060, 8'h12, 1'h0, 8'h99}};

    dmx_exec i_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr));

    // ****************************************
    // Clock, checks and bus tasks
    // ****************************************
    initial
    begin
        pclk = 1'h0;
        forever #2 pclk = ~pclk;
    end

    task automatic chk32(input logic [31:0] g, input logic [31:0] e);
        samples_checked++;
        if (g !== e)
        begin
            err_total++;
            $display("ERROR %0t: data got %h expected %h", $time, g, e);
        end
    endtask

    task automatic chk1(input logic g, input logic e);
        samples_checked++;
        if (g !== e)
        begin
            err_total++;
            $display("ERROR %0t: flag got %b expected %b", $time, g, e);
        end
    endtask

    // Ready is looked at mid-cycle so the edge itself never races the DUT
    task automatic apb(input logic w, input logic [7:0] a,
        input logic [31:0] d);
        int n;
        @(posedge pclk);
        psel <= 1'h1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'h1;
        n = 0;
        do
        begin
            @(negedge pclk);
            n++;
        end
        while (pready !== 1'h1 && n < 64);
        chk1(pready, 1'h1);
        rd = prdata;
        er = pslverr;
        @(posedge pclk);
        psel <= 1'h0;
        penable <= 1'h0;
    endtask

    task automatic rchk(input logic [7:0] a, input logic [31:0] e);
        apb(1'h0, a, 32'h0);
        chk32(rd, e);
    endtask

    task automatic do_reset();
        @(posedge pclk);
        presetn <= 1'h0;
        repeat (2) @(posedge pclk);
        presetn <= 1'h1;
    endtask

    task automatic stop_test();
        $display("errors %0d checks %0d", err_total, samples_checked);
        if (err_total == 0 && samples_checked > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    // Watchdog sized well above the few hundred cycles the run needs
    initial
    begin
        #40000;
        err_total++;
        $display("ERROR %0t: timeout", $time);
        stop_test();
    end

    // ****************************************
    // Main sequence
    // ****************************************
    initial
    begin
        err_total = 0;
        samples_checked = 0;
        {psel, penable, pwrite, paddr, pwdata} = '0;
        presetn = 1'h0;
        repeat (2) @(posedge pclk);
        presetn <= 1'h1;
        rchk(dmx_pkg::OFS_ACC, 32'h0);
        rchk(dmx_pkg::OFS_COUNT, 32'h0);
        foreach (rows[i])
        begin
            apb(1'h1, dmx_pkg::OFS_FADDR, {25'h0, rows[i].fa});
            apb(1'h1, dmx_pkg::OFS_FDATA, {24'h0, rows[i].fv});
            apb(1'h1, dmx_pkg::OFS_ACC, {24'h0, rows[i].acc});
            apb(1'h1, dmx_pkg::OFS_STATUS, {31'h0, rows[i].z});
            apb(1'h1, dmx_pkg::OFS_INSTR, {18'h0, rows[i].ins});
            rchk(dmx_pkg::OFS_ACC, {24'h0, rows[i].eacc});
            rchk(dmx_pkg::OFS_STATUS, {31'h0, rows[i].ez});
            rchk(dmx_pkg::OFS_FDATA, {24'h0, rows[i].ef});
        end
        rchk(dmx_pkg::OFS_COUNT, 32'hA);
        // Back-to-back store, load and copy through one register
        apb(1'h1, dmx_pkg::OFS_ACC, 32'hA5);
        apb(1'h1, dmx_pkg::OFS_FADDR, 32'h22);
        apb(1'h1, dmx_pkg::OFS_INSTR, 32'h00A2);
        apb(1'h1, dmx_pkg::OFS_INSTR, 32'h3000);
        apb(1'h1, dmx_pkg::OFS_INSTR, 32'h0822);
        rchk(dmx_pkg::OFS_ACC, 32'hA5);
        rchk(dmx_pkg::OFS_STATUS, 32'h0);
        // Unmapped address is refused and leaves state alone
        apb(1'h1, 8'h18, 32'hFF);
        chk1(er, 1'h1);
        apb(1'h0, 8'h18, 32'h0);
        chk1(er, 1'h1);
        chk32(rd, 32'h0);
        rchk(dmx_pkg::OFS_ACC, 32'hA5);
        // Second reset in mid-run clears the core state
        do_reset();
        rchk(dmx_pkg::OFS_ACC, 32'h0);
        rchk(dmx_pkg::OFS_COUNT, 32'h0);
        rchk(dmx_pkg::OFS_FDATA, 32'h0);
        stop_test();
    end
endmodule
